// File: verilog/efpc_pkg.sv
// constants and carrier types for the embedded flash program control block
package efpc_pkg;

	localparam logic [15:0] CMD_PORT     = 16'hff0f;
	localparam logic [1:0]  OFS_SEGCTL   = 2'h0;
	localparam logic [1:0]  OFS_TEST     = 2'h1;
	localparam logic [1:0]  OFS_PADDR    = 2'h2;
	localparam logic [1:0]  OFS_PDATA    = 2'h3;
	localparam int          BIT_RUN      = 0;
	localparam int          BIT_OP_LO    = 1;
	localparam int          BIT_OP_HI    = 2;
	localparam int          BIT_VER_LO   = 3;
	localparam int          BIT_VER_HI   = 4;
	localparam int          BIT_KEY_LO   = 5;
	localparam int          BIT_KEY_HI   = 6;
	localparam int          BIT_SEG_LO   = 8;
	localparam int          BIT_SEG_HI   = 15;
	localparam int          BIT_TEST_HI  = 4;
	localparam logic [1:0]  KEY_PATTERN  = 2'h2;
	localparam logic [15:0] ERASE_FILL   = 16'hffff;
	localparam logic [15:0] ZERO_WORD    = 16'h0000;
	localparam logic [7:0]  NO_SEGMENTS  = 8'h00;

	typedef enum logic [1:0] {
		OP_UNDEF   = 2'h0,
		OP_ERASE   = 2'h1,
		OP_WRITE   = 2'h2,
		OP_RECOVER = 2'h3
	} efpc_op_e;

	typedef enum logic [1:0] {
		VER_NORMAL  = 2'h0,
		VER_ONES    = 2'h1,
		VER_ZEROS   = 2'h2,
		VER_INVERSE = 2'h3
	} efpc_ver_e;

	typedef enum logic [0:0] {
		MODE_ARRAY = 1'h0,
		MODE_REGS  = 1'h1
	} efpc_mode_e;

	// one core bus cycle toward the flash module
	typedef struct packed {
		logic        io_wr;
		logic        io_rd;
		logic [15:0] io_addr;
		logic        mem_wr;
		logic        mem_rd;
		logic [15:0] mem_addr;
		logic [15:0] wdata;
	} efpc_req_s;

	typedef struct packed {
		logic [7:0] seg_en;
		efpc_ver_e  ver;
		efpc_op_e   op;
		logic       run;
	} efpc_seg_s;

endpackage

// File: verilog/efpc_flash_ctrl.sv
// register access and pulse control for the embedded flash array
`timescale 1ns/10ps
module efpc_flash_ctrl
	import efpc_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      srst,
	input  wire efpc_req_s req,
	input  wire logic      abort_run,
	input  wire logic      test_mode_pin,
	input  wire logic [15:0] array_rdata,
	output logic [15:0]    rdata_q,
	output logic           rvalid_q,
	output logic           arr_rd_q,
	output logic [15:0]    arr_addr_q,
	output efpc_ver_e      margin_mode_q,
	output efpc_op_e       pulse_op_q,
	output logic [7:0]     seg_pulse_q,
	output logic [15:0]    prog_addr_q,
	output logic [15:0]    prog_data_q,
	output efpc_mode_e     mode_q
);

	typedef struct packed {
		efpc_mode_e  mode;
		efpc_seg_s   seg;
		logic [4:0]  test;
		logic [15:0] paddr;
		logic [15:0] pdata;
		logic        arr_rd;
		logic [15:0] arr_addr;
		logic        st1_v;
		logic        st1_arr;
		logic        st1_lock;
		logic [15:0] st1_data;
		logic [15:0] rdata;
		logic        rvalid;
		efpc_op_e    pulse_op;
		logic [7:0]  seg_pulse;
		logic [2:0]  tsync;
		logic        test_mode;
	} efpc_state_s;

	efpc_state_s s_q;
	efpc_state_s s_d;

	logic        reg_wr;
	logic        reg_rd;
	logic        arr_wr;
	logic        arr_rdreq;
	logic        start_ok;
	logic [15:0] segctl_view;
	logic [15:0] reg_view;
	logic [1:0]  key_in;

	always_comb begin
		s_d = s_q;
		// register view: unlock bits and bit 7 always read zero
		segctl_view = {s_q.seg.seg_en, 3'h0, s_q.seg.ver, s_q.seg.op,
			s_q.seg.run};
		key_in = req.wdata[BIT_KEY_HI:BIT_KEY_LO];

		// accesses decode against the mode in force this cycle
		reg_wr = req.mem_wr && (s_q.mode == MODE_REGS);
		reg_rd = req.mem_rd && (s_q.mode == MODE_REGS);
		arr_wr = req.mem_wr && (s_q.mode == MODE_ARRAY);
		arr_rdreq = req.mem_rd && (s_q.mode == MODE_ARRAY);

		// only the low two address bits matter, so the map repeats
		unique case (req.mem_addr[1:0])
			OFS_SEGCTL: reg_view = segctl_view;
			OFS_TEST:   reg_view = s_q.test_mode ?
				{11'h000, s_q.test} : ZERO_WORD;
			OFS_PADDR:  reg_view = s_q.paddr;
			OFS_PDATA:  reg_view = s_q.pdata;
		endcase

		// start needs the key, a defined op and for erase an all-ones latch
		start_ok = req.wdata[BIT_RUN] && (key_in == KEY_PATTERN)
			&& (req.wdata[BIT_OP_HI:BIT_OP_LO] != OP_UNDEF)
			&& ((req.wdata[BIT_OP_HI:BIT_OP_LO] != OP_ERASE)
			|| (s_q.pdata == ERASE_FILL));

		// mode switching by io commands; the write command wins a tie
		if (req.io_wr && (req.io_addr == CMD_PORT)) begin
			s_d.mode = MODE_REGS;
		end else if (req.io_rd && (req.io_addr == CMD_PORT)) begin
			s_d.mode = MODE_ARRAY;
		end

		// register writes
		if (reg_wr) begin
			unique case (req.mem_addr[1:0])
				OFS_SEGCTL: begin
					if (s_q.seg.run) begin
						// running: only the run bit may drop
						if (!req.wdata[BIT_RUN]) begin
							s_d.seg.run = 1'b0;
						end
					end else begin
						s_d.seg.seg_en =
							req.wdata[BIT_SEG_HI:BIT_SEG_LO];
						s_d.seg.ver = efpc_ver_e'(
							req.wdata[BIT_VER_HI:BIT_VER_LO]);
						s_d.seg.op = efpc_op_e'(
							req.wdata[BIT_OP_HI:BIT_OP_LO]);
						s_d.seg.run = start_ok;
					end
				end
				OFS_TEST: begin
					if (s_q.test_mode) begin
						s_d.test = req.wdata[BIT_TEST_HI:0];
					end
				end
				OFS_PADDR: begin
					if (!s_q.seg.run) begin
						s_d.paddr = req.wdata;
					end
				end
				OFS_PDATA: begin
					if (!s_q.seg.run) begin
						s_d.pdata = req.wdata;
					end
				end
			endcase
		end

		// array-mode writes land in the latches unless a run is active
		if (arr_wr && !s_q.seg.run) begin
			s_d.paddr = req.mem_addr;
			s_d.pdata = req.wdata;
		end

		// read pipeline: request, then array or register value, then answer
		s_d.arr_rd = arr_rdreq && !s_q.seg.run;
		if (arr_rdreq) begin
			s_d.arr_addr = req.mem_addr;
		end
		s_d.st1_v = arr_rdreq || reg_rd;
		s_d.st1_arr = arr_rdreq;
		s_d.st1_lock = s_q.seg.run;
		s_d.st1_data = reg_rd ? reg_view : ZERO_WORD;
		s_d.rvalid = s_q.st1_v;
		if (s_q.st1_v) begin
			if (s_q.st1_arr) begin
				// reads during a run are undefined; zero is returned
				s_d.rdata = s_q.st1_lock ? ZERO_WORD : array_rdata;
			end else begin
				s_d.rdata = s_q.st1_data;
			end
		end

		// pulses reach the array only while run is set and abort is low
		if (s_d.seg.run && !abort_run) begin
			s_d.pulse_op = s_d.seg.op;
			s_d.seg_pulse = s_d.seg.seg_en;
		end else begin
			s_d.pulse_op = OP_UNDEF;
			s_d.seg_pulse = NO_SEGMENTS;
		end

		// test mode strap: three stages, change taken when last two agree
		s_d.tsync = {s_q.tsync[1:0], test_mode_pin};
		if (s_q.tsync[1] == s_q.tsync[2]) begin
			s_d.test_mode = s_q.tsync[2];
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata_q       = s_q.rdata;
	assign rvalid_q      = s_q.rvalid;
	assign arr_rd_q      = s_q.arr_rd;
	assign arr_addr_q    = s_q.arr_addr;
	assign margin_mode_q = s_q.seg.ver;
	assign pulse_op_q    = s_q.pulse_op;
	assign seg_pulse_q   = s_q.seg_pulse;
	assign prog_addr_q   = s_q.paddr;
	assign prog_data_q   = s_q.pdata;
	assign mode_q        = s_q.mode;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	a_cmd_enter_regs: assert property (
		req.io_wr && (req.io_addr == CMD_PORT) |=> mode_q == MODE_REGS)
		else $error("output command did not enter register mode");

	a_cmd_leave_regs: assert property (
		!req.io_wr && req.io_rd && (req.io_addr == CMD_PORT)
		|=> mode_q == MODE_ARRAY)
		else $error("input command did not return to array mode");

	a_reg_mode_noarr: assert property (
		(mode_q == MODE_REGS) && req.mem_rd |=> !arr_rd_q)
		else $error("array read issued in register mode");

	a_reset_clear: assert property (
		$past(srst) |-> (s_q.seg == '0) && (seg_pulse_q == NO_SEGMENTS))
		else $error("segment control not cleared by reset");

	a_alias_read: assert property (
		reg_rd && !req.mem_wr && (req.mem_addr[1:0] == OFS_PADDR)
		&& !(arr_wr) |-> ##2 rvalid_q && (rdata_q == $past(prog_addr_q, 2)))
		else $error("aliased address latch read wrong");

	a_key_reads_zero: assert property (
		reg_rd && (req.mem_addr[1:0] == OFS_SEGCTL)
		|-> ##2 rvalid_q && (rdata_q[BIT_KEY_HI:BIT_KEY_LO] == 2'h0))
		else $error("unlock bits read back nonzero");

	a_key_needed: assert property (
		$rose(s_q.seg.run) |-> $past(req.mem_wr)
		&& ($past(req.wdata[BIT_KEY_HI:BIT_KEY_LO]) == KEY_PATTERN))
		else $error("run started without unlock pattern");

	a_erase_fill: assert property (
		$rose(s_q.seg.run) && (s_q.seg.op == OP_ERASE)
		|-> prog_data_q == ERASE_FILL)
		else $error("erase started without all-ones data latch");

	a_pulse_gate: assert property (
		(seg_pulse_q != NO_SEGMENTS) |-> s_q.seg.run && $past(!abort_run))
		else $error("array pulse without run or under abort");

	a_abort_stop: assert property (
		abort_run |=> (seg_pulse_q == NO_SEGMENTS) && (pulse_op_q == OP_UNDEF))
		else $error("abort did not stop pulse");

	a_pulse_segments: assert property (
		(pulse_op_q != OP_UNDEF) |-> (seg_pulse_q == s_q.seg.seg_en)
		&& (pulse_op_q == s_q.seg.op))
		else $error("pulse does not follow segment enables");

	a_frozen_run: assert property (
		s_q.seg.run |=> $stable(s_q.seg.seg_en) && $stable(s_q.seg.op)
		&& $stable(s_q.seg.ver))
		else $error("segment control changed while running");

	a_latch_locked: assert property (
		s_q.seg.run |=> $stable(prog_addr_q) && $stable(prog_data_q))
		else $error("latches changed while running");

	a_array_capture: assert property (
		arr_wr && !s_q.seg.run
		|=> (prog_addr_q == $past(req.mem_addr))
		&& (prog_data_q == $past(req.wdata)))
		else $error("array write not captured in latches");

	a_data_reg_load: assert property (
		reg_wr && !s_q.seg.run && (req.mem_addr[1:0] == OFS_PDATA)
		|=> prog_data_q == $past(req.wdata))
		else $error("data latch register write lost");

	a_test_hidden: assert property (
		reg_rd && !s_q.test_mode && (req.mem_addr[1:0] == OFS_TEST)
		|-> ##2 rdata_q == ZERO_WORD)
		else $error("test register visible outside test mode");

	a_array_issue: assert property (
		arr_rdreq && !s_q.seg.run
		|=> arr_rd_q && (arr_addr_q == $past(req.mem_addr)))
		else $error("array read not issued in array mode");

	a_locked_read: assert property (
		arr_rdreq && s_q.seg.run
		|=> !arr_rd_q ##1 (rvalid_q && (rdata_q == ZERO_WORD)))
		else $error("array read during run not suppressed");

	a_read_latency: assert property (
		(reg_rd || arr_rdreq) |-> ##2 rvalid_q)
		else $error("read answer not two cycles after request");

	a_data_alias: assert property (
		reg_rd && (req.mem_addr[1:0] == OFS_PDATA)
		|-> ##2 rvalid_q && (rdata_q == $past(prog_data_q, 2)))
		else $error("aliased data latch read wrong");

	a_seg_load: assert property (
		reg_wr && !s_q.seg.run && (req.mem_addr[1:0] == OFS_SEGCTL)
		|=> s_q.seg.seg_en == $past(req.wdata[BIT_SEG_HI:BIT_SEG_LO]))
		else $error("segment enables not loaded");

	a_margin_load: assert property (
		reg_wr && !s_q.seg.run && (req.mem_addr[1:0] == OFS_SEGCTL)
		|=> margin_mode_q == $past(req.wdata[BIT_VER_HI:BIT_VER_LO]))
		else $error("verify mode not loaded");

	a_op_load: assert property (
		reg_wr && !s_q.seg.run && (req.mem_addr[1:0] == OFS_SEGCTL)
		|=> s_q.seg.op == $past(req.wdata[BIT_OP_HI:BIT_OP_LO]))
		else $error("operation field not loaded");

	a_no_undef_run: assert property (
		s_q.seg.run |-> (s_q.seg.op != OP_UNDEF))
		else $error("run set with undefined operation");

	a_bad_key: assert property (
		reg_wr && !s_q.seg.run && (req.mem_addr[1:0] == OFS_SEGCTL)
		&& (key_in != KEY_PATTERN) |=> !s_q.seg.run)
		else $error("run started with wrong unlock bits");

	a_run_clear: assert property (
		s_q.seg.run && reg_wr && (req.mem_addr[1:0] == OFS_SEGCTL)
		&& !req.wdata[BIT_RUN] |=> !s_q.seg.run && (pulse_op_q == OP_UNDEF))
		else $error("run bit did not clear");

	a_addr_reg_load: assert property (
		reg_wr && !s_q.seg.run && (req.mem_addr[1:0] == OFS_PADDR)
		|=> prog_addr_q == $past(req.wdata))
		else $error("address latch register write lost");

	a_test_locked: assert property (
		reg_wr && !s_q.test_mode && (req.mem_addr[1:0] == OFS_TEST)
		|=> $stable(s_q.test))
		else $error("test register written outside test mode");

	a_reset_mode: assert property (
		$past(srst) |-> (mode_q == MODE_ARRAY) && (pulse_op_q == OP_UNDEF))
		else $error("reset left mode or pulse active");

	a_pulse_start: assert property (
		$rose(s_q.seg.run) && !$past(abort_run)
		|-> seg_pulse_q == s_q.seg.seg_en)
		else $error("pulse missing after run start");

	c_erase_run: cover property (
		$rose(s_q.seg.run) && (s_q.seg.op == OP_ERASE));
	c_write_run: cover property (
		$rose(s_q.seg.run) && (s_q.seg.op == OP_WRITE));
	c_abort_run: cover property (s_q.seg.run && abort_run);
	c_reg_read: cover property (reg_rd ##2 rvalid_q);
	c_recover_run: cover property (
		$rose(s_q.seg.run) && (s_q.seg.op == OP_RECOVER));

endmodule

// File: sim/efpc_array_model.sv
// stand-in for the flash array behind the control block
`timescale 1ns/10ps
module efpc_array_model (
	input  wire logic        clk,
	input  wire logic        arr_rd_q,
	input  wire logic [15:0] arr_addr_q,
	output logic      [15:0] array_rdata
);
	logic [15:0] last_q = 16'h0000;
	always @(posedge clk) begin
		last_q <= array_rdata;
	end
	// outside a read the bus flips every cycle so stale data never matches
	assign array_rdata = arr_rd_q ? (arr_addr_q ^ 16'h5a5a) : ~last_q;
endmodule

// File: sim/tb.sv
// self-checking bench for the flash program control block
`timescale 1ns/10ps
module tb
	import efpc_pkg::*;
;
	logic        clk;
	logic        srst;
	logic        abort_run;
	logic        test_mode_pin;
	efpc_req_s   req;
	logic [15:0] array_rdata;
	logic [15:0] rdata_q;
	logic [15:0] arr_addr_q;
	logic [15:0] prog_addr_q;
	logic [15:0] prog_data_q;
	logic        rvalid_q;
	logic        arr_rd_q;
	logic [7:0]  seg_pulse_q;
	efpc_ver_e   margin_mode_q;
	efpc_op_e    pulse_op_q;
	efpc_mode_e  mode_q;
	int          errors = 0;
	int          total_checks = 0;
	int          reads = 0;
	logic [15:0] d;

	efpc_flash_ctrl i_efpc_flash_ctrl (.clk(clk), .srst(srst), .req(req),
		.abort_run(abort_run), .test_mode_pin(test_mode_pin),
		.array_rdata(array_rdata), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
		.arr_rd_q(arr_rd_q), .arr_addr_q(arr_addr_q),
		.margin_mode_q(margin_mode_q), .pulse_op_q(pulse_op_q),
		.seg_pulse_q(seg_pulse_q), .prog_addr_q(prog_addr_q),
		.prog_data_q(prog_data_q), .mode_q(mode_q));
	efpc_array_model i_efpc_array_model (.clk(clk), .arr_rd_q(arr_rd_q),
		.arr_addr_q(arr_addr_q), .array_rdata(array_rdata));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (arr_rd_q === 1'b1)
			reads <= reads + 1;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		req.mem_wr = 1'b1;
		req.mem_addr = a;
		req.wdata = v;
		step(1);
		req.mem_wr = 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [15:0] a, output logic [15:0] v);
		int n;
		req.mem_rd = 1'b1;
		req.mem_addr = a;
		step(1);
		req.mem_rd = 1'b0;
		n = 0;
		while (rvalid_q !== 1'b1 && n < 4) begin
			step(1);
			n++;
		end
		chk(16'(n < 4), 16'h0001);
		v = rdata_q;
	endtask

	// out command when hi is set, in command otherwise
	task automatic cmd(input logic hi);
		req.io_wr = hi;
		req.io_rd = !hi;
		req.io_addr = CMD_PORT;
		step(1);
		req.io_wr = 1'b0;
		req.io_rd = 1'b0;
		step(1);
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#500000;
		errors++;
		$display("watchdog expired");
		conclude();
	end

	initial begin
		req = '0;
		abort_run = 1'b0;
		test_mode_pin = 1'b0;
		srst = 1'b1;
		step(5);
		srst = 1'b0;
		chk(16'(pulse_op_q), 16'h0000);
		step(1);
		cmd(1'b1);
		chk(16'(mode_q), 16'h0001);
		rd(16'h0004, d);
		chk(d, 16'h0000);
		wr(16'h0013, 16'hffff);
		wr(16'h00a6, 16'h1234);
		chk(prog_data_q, 16'hffff);
		chk(prog_addr_q, 16'h1234);
		rd(16'h0007, d);
		chk(d, 16'hffff);
		rd(16'h0002, d);
		chk(d, 16'h1234);
		wr(16'h0001, 16'h001f);
		rd(16'h0005, d);
		chk(d, 16'h0000);
		chk(16'(reads), 16'h0000);
		$display("test map done");
		for (int v = 0; v < 4; v++) begin
			wr(16'h0000, {9'h000, 2'h3, v[1:0], 3'h0});
			chk(16'(margin_mode_q), 16'(v));
			rd(16'h0000, d);
			chk(d, {11'h000, v[1:0], 3'h0});
		end
		$display("test verify done");
		wr(16'h0003, 16'h1234);
		wr(16'h0000, 16'hff43);
		step(1);
		chk(16'(pulse_op_q), 16'h0000);
		wr(16'h0003, 16'hffff);
		wr(16'h0000, 16'hff43);
		step(1);
		chk(16'(pulse_op_q), 16'(OP_ERASE));
		chk(16'(seg_pulse_q), 16'h00ff);
		wr(16'h0000, 16'h0f43);
		wr(16'h0003, 16'h0000);
		wr(16'h0002, 16'h0000);
		step(1);
		chk(16'(seg_pulse_q), 16'h00ff);
		chk(prog_data_q, 16'hffff);
		abort_run = 1'b1;
		step(2);
		chk(16'(pulse_op_q), 16'h0000);
		abort_run = 1'b0;
		cmd(1'b0);
		chk(16'(mode_q), 16'h0000);
		rd(16'h0040, d);
		chk(d, 16'h0000);
		wr(16'h8888, 16'h0000);
		chk(prog_addr_q, 16'h1234);
		chk(16'(reads), 16'h0000);
		cmd(1'b1);
		// erase hold cut short: the block does not time pulses itself
		wr(16'h0000, 16'h0040);
		step(1);
		chk(16'(pulse_op_q), 16'h0000);
		$display("test erase done");
		for (int op = 0; op < 4; op++) begin
			wr(16'h0000, {8'h0f, 1'b0, KEY_PATTERN, 2'h0, op[1:0], 1'b1});
			step(1);
			chk(16'(pulse_op_q), 16'(op));
			chk(16'(seg_pulse_q), (op == 0) ? 16'h0000 : 16'h000f);
			// start edge to clear edge spans 5000 cycles, 100 us
			if (op == 2)
				step(4997);
			wr(16'h0000, 16'h0040);
			step(1);
			if (op == 2) begin
				wr(16'h0000, 16'h0010);
				chk(16'(margin_mode_q), 16'(VER_ZEROS));
			end
		end
		wr(16'h0000, 16'h0f25);
		step(1);
		chk(16'(pulse_op_q), 16'h0000);
		wr(16'h0000, 16'h0f47);
		chk(16'(seg_pulse_q), 16'h000f);
		srst = 1'b1;
		step(2);
		srst = 1'b0;
		chk(16'(seg_pulse_q), 16'h0000);
		chk(16'(mode_q), 16'h0000);
		step(1);
		cmd(1'b1);
		rd(16'h0008, d);
		chk(d, 16'h0000);
		$display("test reset done");
		$display("test ops done");
		cmd(1'b0);
		wr(16'h9abc, 16'hff00);
		chk(prog_addr_q, 16'h9abc);
		chk(prog_data_q, 16'hff00);
		rd(16'h0042, d);
		chk(d, 16'h0042 ^ 16'h5a5a);
		chk(arr_addr_q, 16'h0042);
		chk(16'(reads), 16'h0001);
		cmd(1'b1);
		test_mode_pin = 1'b1;
		step(6);
		wr(16'h0001, 16'h001f);
		rd(16'h0001, d);
		chk(d, 16'h001f);
		$display("test array done");
		conclude();
	end
endmodule
